// ==== hw/acv_pkg.sv ====
// Package with register map, field layout and shared types of the converter control block.
package acv_pkg;
  localparam logic [7:0] INPUT_CONTROL_ADDR = 8'ha5;
  localparam logic [7:0] RESULT_LOW_ADDR = 8'hac;
  localparam logic [7:0] RESULT_HIGH_ADDR = 8'had;
  localparam logic [7:0] INPUT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RESULT_LOW_RESET = 8'h00;
  localparam logic [7:0] RESULT_HIGH_RESET = 8'h00;
  localparam int INPUT_CONNECT_BIT = 7;
  localparam int INTERNAL_REFERENCE_BIT = 6;
  localparam int INPUT_PAIR_MODE_BIT = 5;
  localparam int TRIGGER_SELECT_LSB = 3;
  localparam int CHANNEL_SELECT_LSB = 0;
  localparam int RESULT_WIDTH = 10;
  localparam logic [1:0] TRIGGER_SOFTWARE = 2'h0;
  localparam logic [1:0] TRIGGER_TIMER0 = 2'h1;
  localparam logic [1:0] TRIGGER_TIMER1 = 2'h2;
  localparam logic [1:0] TRIGGER_TIMER2 = 2'h3;
  // Analog source codes for the positive and negative converter inputs.
  localparam logic [3:0] SRC_PORT0_LINE0 = 4'h0;
  localparam logic [3:0] SRC_HALF_SUPPLY = 4'h8;
  localparam logic [3:0] SRC_TEMPERATURE = 4'h9;
  localparam logic [3:0] SRC_REFERENCE = 4'ha;
  localparam logic [3:0] SRC_NONE = 4'hf;

  typedef struct packed {
    logic input_connect_control;
    logic internal_reference_select;
    logic input_pair_mode;
    logic [1:0] conversion_trigger_select;
    logic [2:0] input_channel_select;
  } acv_input_control_t;

  typedef struct packed {
    logic [3:0] positive_source;
    logic [3:0] negative_source;
    logic use_internal_reference;
    logic temperature_from_sensor;
    logic input_pair_mode;
    logic input_connect;
    logic reserved_combination;
  } acv_route_t;

  typedef struct packed {
    logic write_strobe;
    logic [7:0] address;
    logic [7:0] write_data;
  } acv_sfr_write_t;
endpackage

// ==== hw/acv_route_decode.sv ====
// Input multiplexer decode from the latched input control setting.
`timescale 1ns/10ps
module acv_route_decode (
  input wire acv_pkg::acv_input_control_t control,
  output acv_pkg::acv_route_t route
);
  wire [2:0] chan = control.input_channel_select;
  wire pair = control.input_pair_mode;
  wire [3:0] single_pos;
  wire [3:0] single_neg;
  wire [3:0] pair_pos;
  wire [3:0] pair_neg;
  wire pair_reserved;

  // Codes 0 to 5 map to lines 0 to 5, code 6 is temperature, code 7 is line 6.
  assign single_pos = (chan == 3'h6) ? acv_pkg::SRC_TEMPERATURE :
                      (chan == 3'h7) ? (acv_pkg::SRC_PORT0_LINE0 + 4'h6) :
                      (acv_pkg::SRC_PORT0_LINE0 + {1'b0, chan});
  assign single_neg = (chan == 3'h6) ? acv_pkg::SRC_REFERENCE : acv_pkg::SRC_HALF_SUPPLY;
  assign pair_reserved = chan[2] | (chan[1:0] == 2'h3);
  assign pair_pos = pair_reserved ? acv_pkg::SRC_NONE : (acv_pkg::SRC_PORT0_LINE0 + {chan[1:0], 2'h0} / 4'h2);
  assign pair_neg = pair_reserved ? acv_pkg::SRC_NONE : (pair_pos + 4'h1);
  // One driver for the whole route word, so no tool has to merge partial drivers.
  assign route = '{
    positive_source: pair ? pair_pos : single_pos,
    negative_source: pair ? pair_neg : single_neg,
    use_internal_reference: control.internal_reference_select,
    temperature_from_sensor: control.internal_reference_select,
    input_pair_mode: pair,
    input_connect: control.input_connect_control,
    reserved_combination: pair & pair_reserved
  };
endmodule

// ==== hw/acv_converter_control.sv ====
// Converter input control, start/busy handling and result formatting.
// Operation
// - Reference bit picks internal reference or supply.
// - Pair mode bit picks differential or single-ended.
// - Trigger field picks software or timer start.
// - Single codes 0-5 route lines, negative half-supply.
// - Code 6 temperature/reference, code 7 line six.
// - Differential codes pair lines 0/1, 2/3, 4/5.
// - Temperature source follows reference select bit.
// - Input control at A5, resets to zero.
// - Result low at AC, resets to zero.
// - Right justified: low byte holds bits 7-0.
// - Left justified: bits 1-0 top, rest zero.
// - Justify bit selects right sign-extended or left.
// - Right justified high: bits 9-8, sign copies.
// - Start bit begins conversion, stays busy until done.
`timescale 1ns/10ps
module acv_converter_control (
  input wire logic CLK,
  input wire logic SRST,
  input wire acv_pkg::acv_sfr_write_t SFR_WR,
  input wire logic [7:0] SFR_RD_ADDR,
  output logic [7:0] SFR_RD_DATA,
  input wire logic START_WRITE,
  input wire logic RESULT_JUSTIFY_LEFT,
  input wire logic TIMER0_OVERFLOW,
  input wire logic TIMER1_OVERFLOW,
  input wire logic TIMER2_OVERFLOW,
  input wire logic CONVERSION_DONE,
  input wire logic [9:0] CONVERSION_RESULT,
  output logic CONVERT_START,
  output logic CONVERT_START_BUSY,
  output acv_pkg::acv_route_t ROUTE
);
  typedef enum logic {ACV_IDLE, ACV_BUSY} acv_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  acv_pkg::acv_input_control_t control_q, control_d;
  acv_pkg::acv_input_control_t latched_q, latched_d;
  acv_pkg::acv_route_t route_w;
  acv_state_t state_q, state_d;
  logic [7:0] result_low_q, result_low_d;
  logic [7:0] result_high_q, result_high_d;
  logic [7:0] rd_data_d;
  logic start_q;

  wire ctl_write = SFR_WR.write_strobe && (SFR_WR.address == acv_pkg::INPUT_CONTROL_ADDR);
  wire low_write = SFR_WR.write_strobe && (SFR_WR.address == acv_pkg::RESULT_LOW_ADDR);
  wire high_write = SFR_WR.write_strobe && (SFR_WR.address == acv_pkg::RESULT_HIGH_ADDR);
  wire [1:0] trig = control_q.conversion_trigger_select;
  // Software start only counts in software mode; timers only in their own mode.
  wire trigger_hit = (trig == acv_pkg::TRIGGER_SOFTWARE) ? START_WRITE :
                     (trig == acv_pkg::TRIGGER_TIMER0) ? TIMER0_OVERFLOW :
                     (trig == acv_pkg::TRIGGER_TIMER1) ? TIMER1_OVERFLOW : TIMER2_OVERFLOW;
  wire start_now = (state_q == ACV_IDLE) && trigger_hit;
  wire [7:0] fmt_low = RESULT_JUSTIFY_LEFT ? {CONVERSION_RESULT[1:0], 6'h00} :
                                             CONVERSION_RESULT[7:0];
  wire [7:0] fmt_high = RESULT_JUSTIFY_LEFT ? CONVERSION_RESULT[9:2] :
                                              {{6{CONVERSION_RESULT[9]}}, CONVERSION_RESULT[9:8]};
  wire finish = (state_q == ACV_BUSY) && CONVERSION_DONE;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    control_d = ctl_write ? acv_pkg::acv_input_control_t'(SFR_WR.write_data) : control_q;
    latched_d = start_now ? control_q : latched_q;
    state_d = state_q;
    case (state_q)
      ACV_IDLE: begin
        if (start_now) begin
          state_d = ACV_BUSY;
        end
      end
      ACV_BUSY: begin
        if (CONVERSION_DONE) begin
          state_d = ACV_IDLE;
        end
      end
      default: begin
        state_d = ACV_IDLE;
      end
    endcase
    // A completing conversion wins over a software write in the same cycle.
    result_low_d = finish ? fmt_low : (low_write ? SFR_WR.write_data : result_low_q);
    result_high_d = finish ? fmt_high : (high_write ? SFR_WR.write_data : result_high_q);
    case (SFR_RD_ADDR)
      acv_pkg::INPUT_CONTROL_ADDR: rd_data_d = control_q;
      acv_pkg::RESULT_LOW_ADDR: rd_data_d = result_low_q;
      acv_pkg::RESULT_HIGH_ADDR: rd_data_d = result_high_q;
      default: rd_data_d = 8'h00;
    endcase
  end

  acv_route_decode u_route (
    .control(latched_q),
    .route(route_w)
  );

  always_ff @(posedge CLK) begin
    if (SRST) begin
      control_q <= acv_pkg::INPUT_CONTROL_RESET;
      latched_q <= acv_pkg::INPUT_CONTROL_RESET;
      state_q <= ACV_IDLE;
      result_low_q <= acv_pkg::RESULT_LOW_RESET;
      result_high_q <= acv_pkg::RESULT_HIGH_RESET;
      start_q <= 1'b0;
      SFR_RD_DATA <= 8'h00;
      ROUTE <= '0;
    end else begin
      control_q <= control_d;
      latched_q <= latched_d;
      state_q <= state_d;
      result_low_q <= result_low_d;
      result_high_q <= result_high_d;
      start_q <= start_now;
      SFR_RD_DATA <= rd_data_d;
      ROUTE <= route_w;
    end
  end

  assign CONVERT_START = start_q;
  assign CONVERT_START_BUSY = (state_q == ACV_BUSY);

  ////////////////////////////////////////////////////////////////////////////////
  chk_control_reset_zero: assert property (@(posedge CLK) $past(SRST) |-> control_q == 8'h00)
    else $error("input control not zero after reset");
  chk_low_reset_zero: assert property (@(posedge CLK) $past(SRST) |-> result_low_q == 8'h00)
    else $error("result low not zero after reset");
  chk_low_right_just: assert property (@(posedge CLK) disable iff (SRST)
    finish && !RESULT_JUSTIFY_LEFT |=> result_low_q == $past(CONVERSION_RESULT[7:0]))
    else $error("right justified low byte wrong");
  chk_low_left_just: assert property (@(posedge CLK) disable iff (SRST)
    finish && RESULT_JUSTIFY_LEFT |=> result_low_q[5:0] == 6'h00 && result_low_q[7:6] == $past(CONVERSION_RESULT[1:0]))
    else $error("left justified low byte wrong");
  chk_high_sign_ext: assert property (@(posedge CLK) disable iff (SRST)
    finish && !RESULT_JUSTIFY_LEFT |=> result_high_q == {{6{$past(CONVERSION_RESULT[9])}}, $past(CONVERSION_RESULT[9:8])})
    else $error("high byte sign extension wrong");
  chk_high_left_just: assert property (@(posedge CLK) disable iff (SRST)
    finish && RESULT_JUSTIFY_LEFT |=> result_high_q == $past(CONVERSION_RESULT[9:2]))
    else $error("left justified high byte wrong");
  chk_soft_start_busy: assert property (@(posedge CLK) disable iff (SRST)
    !CONVERT_START_BUSY && trig == acv_pkg::TRIGGER_SOFTWARE && START_WRITE |=> CONVERT_START_BUSY && CONVERT_START)
    else $error("software start did not set busy");
  chk_busy_clears: assert property (@(posedge CLK) disable iff (SRST)
    CONVERT_START_BUSY && CONVERSION_DONE |=> !CONVERT_START_BUSY)
    else $error("busy did not clear on completion");
  chk_timer0_start: assert property (@(posedge CLK) disable iff (SRST)
    !CONVERT_START_BUSY && trig == acv_pkg::TRIGGER_TIMER0 |-> ##1 (CONVERT_START == $past(TIMER0_OVERFLOW)))
    else $error("timer 0 trigger mismatch");
  chk_setting_held: assert property (@(posedge CLK) disable iff (SRST)
    CONVERT_START_BUSY && !finish |=> latched_q == $past(latched_q))
    else $error("setting changed during conversion");
  chk_single_route: assert property (@(posedge CLK) disable iff (SRST)
    !latched_q.input_pair_mode && latched_q.input_channel_select < 3'h6 |=>
    ROUTE.negative_source == acv_pkg::SRC_HALF_SUPPLY)
    else $error("single-ended negative input wrong");
  chk_input_pair_mode_route: assert property (@(posedge CLK) disable iff (SRST)
    latched_q.input_pair_mode && latched_q.input_channel_select == 3'h1 |=> ROUTE.positive_source == 4'h2 &&
    ROUTE.negative_source == 4'h3)
    else $error("differential pair wrong");
  chk_temp_route: assert property (@(posedge CLK) disable iff (SRST)
    !latched_q.input_pair_mode && latched_q.input_channel_select == 3'h6 |=>
    ROUTE.positive_source == acv_pkg::SRC_TEMPERATURE && ROUTE.negative_source == acv_pkg::SRC_REFERENCE)
    else $error("temperature route wrong");
  chk_reference_follow: assert property (@(posedge CLK) disable iff (SRST)
    1'b1 |=> ROUTE.use_internal_reference == $past(latched_q.internal_reference_select) &&
    ROUTE.temperature_from_sensor == ROUTE.use_internal_reference)
    else $error("reference select not followed");
  chk_timer1_start: assert property (@(posedge CLK) disable iff (SRST)
    !CONVERT_START_BUSY && trig == acv_pkg::TRIGGER_TIMER1 |-> ##1 (CONVERT_START == $past(TIMER1_OVERFLOW)))
    else $error("timer 1 trigger mismatch");
  chk_timer2_start: assert property (@(posedge CLK) disable iff (SRST)
    !CONVERT_START_BUSY && trig == acv_pkg::TRIGGER_TIMER2 |-> ##1 (CONVERT_START == $past(TIMER2_OVERFLOW)))
    else $error("timer 2 trigger mismatch");
  chk_soft_no_timer: assert property (@(posedge CLK) disable iff (SRST)
    trig == acv_pkg::TRIGGER_SOFTWARE && !START_WRITE |=> !CONVERT_START)
    else $error("start without software request");
  chk_no_start_busy: assert property (@(posedge CLK) disable iff (SRST)
    CONVERT_START_BUSY |=> !CONVERT_START)
    else $error("start raised while busy");
  chk_start_one_cycle: assert property (@(posedge CLK) disable iff (SRST)
    CONVERT_START |=> !CONVERT_START)
    else $error("start pulse longer than one cycle");
  chk_busy_held: assert property (@(posedge CLK) disable iff (SRST)
    CONVERT_START_BUSY && !CONVERSION_DONE |=> CONVERT_START_BUSY)
    else $error("busy dropped before completion");
  chk_latch_at_start: assert property (@(posedge CLK) disable iff (SRST)
    start_now |=> latched_q == $past(control_q))
    else $error("settings not taken at start");
  chk_control_write: assert property (@(posedge CLK) disable iff (SRST)
    ctl_write |=> control_q == $past(SFR_WR.write_data))
    else $error("input control write lost");
  chk_control_hold: assert property (@(posedge CLK) disable iff (SRST)
    !ctl_write |=> $stable(control_q))
    else $error("input control changed without write");
  chk_low_write: assert property (@(posedge CLK) disable iff (SRST)
    low_write && !finish |=> result_low_q == $past(SFR_WR.write_data))
    else $error("result low write lost");
  chk_low_hold: assert property (@(posedge CLK) disable iff (SRST)
    !finish && !low_write |=> $stable(result_low_q))
    else $error("result low changed without cause");
  chk_high_write: assert property (@(posedge CLK) disable iff (SRST)
    high_write && !finish |=> result_high_q == $past(SFR_WR.write_data))
    else $error("result high write lost");
  chk_read_control: assert property (@(posedge CLK) disable iff (SRST)
    SFR_RD_ADDR == acv_pkg::INPUT_CONTROL_ADDR |=> SFR_RD_DATA == $past(control_q))
    else $error("input control read wrong");
  chk_read_low: assert property (@(posedge CLK) disable iff (SRST)
    SFR_RD_ADDR == acv_pkg::RESULT_LOW_ADDR |=> SFR_RD_DATA == $past(result_low_q))
    else $error("result low read wrong");
  chk_first_pair: assert property (@(posedge CLK) disable iff (SRST)
    latched_q.input_pair_mode && latched_q.input_channel_select == 3'h0 |=> ROUTE.positive_source == 4'h0 &&
    ROUTE.negative_source == 4'h1)
    else $error("first differential pair wrong");
  chk_line_six: assert property (@(posedge CLK) disable iff (SRST)
    !latched_q.input_pair_mode && latched_q.input_channel_select == 3'h7 |=>
    ROUTE.positive_source == 4'h6 && ROUTE.negative_source == acv_pkg::SRC_HALF_SUPPLY)
    else $error("line six route wrong");
  cov_soft_conv: cover property (@(posedge CLK) disable iff (SRST) CONVERT_START ##[1:20] finish);
  cov_left_result: cover property (@(posedge CLK) disable iff (SRST) finish && RESULT_JUSTIFY_LEFT);
  cov_timer2_start: cover property (@(posedge CLK) disable iff (SRST) start_now && trig == acv_pkg::TRIGGER_TIMER2);
  cov_input_pair_mode_mode: cover property (@(posedge CLK) disable iff (SRST) ROUTE.input_pair_mode && !ROUTE.reserved_combination);
  cov_timer0_start: cover property (@(posedge CLK) disable iff (SRST) start_now && trig == acv_pkg::TRIGGER_TIMER0);
endmodule

// ==== tb/acv_analog_model.sv ====
// Behavioural analog converter that answers each start pulse after a set delay.
`timescale 1ns/10ps
module acv_analog_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] delay,
  input wire logic [9:0] value,
  output logic done,
  output logic [9:0] result
);
  logic [7:0] cnt_q = 8'h00;
  initial done = 1'b0;
  initial result = 10'h000;
  always @(posedge clk) begin
    done <= (cnt_q == 8'h01);
    // Outside the done cycle the result toggles, so stale data never passes for fresh data.
    result <= (cnt_q == 8'h01) ? value : ~result;
    if (start) begin
      cnt_q <= delay;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

// ==== tb/adc_input_select_result_format_test.sv ====
// Self-checking bench for the converter input control, start handling and result formatting.
`timescale 1ns/10ps
module adc_input_select_result_format_test;
  logic clk, srst, just, done, start, busy;
  logic [3:0] trig;
  logic [7:0] rd_addr, rd_data, dly;
  logic [9:0] val, res;
  acv_pkg::acv_sfr_write_t wr;
  acv_pkg::acv_route_t route;
  int err_total = 0;
  int check_count = 0;

  acv_converter_control i_acv_converter_control (.CLK(clk), .SRST(srst), .SFR_WR(wr), .SFR_RD_ADDR(rd_addr),
    .SFR_RD_DATA(rd_data), .START_WRITE(trig[0]), .RESULT_JUSTIFY_LEFT(just), .TIMER0_OVERFLOW(trig[1]),
    .TIMER1_OVERFLOW(trig[2]), .TIMER2_OVERFLOW(trig[3]), .CONVERSION_DONE(done), .CONVERSION_RESULT(res),
    .CONVERT_START(start), .CONVERT_START_BUSY(busy), .ROUTE(route));
  acv_analog_model i_acv_analog_model (.clk(clk), .start(start), .delay(dly), .value(val), .done(done),
    .result(res));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  task finish_test();
    $display("checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= '{1'b1, a, d};
    @(posedge clk);
    wr.write_strobe <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_addr <= a;
    @(posedge clk);
    #1;
    cmp("read data", 16'(e), 16'(rd_data));
  endtask

  function automatic acv_pkg::acv_route_t exp_route(input logic [7:0] c);
    acv_pkg::acv_route_t r;
    r.use_internal_reference = c[6];
    r.temperature_from_sensor = c[6];
    r.input_pair_mode = c[5];
    r.input_connect = c[7];
    r.reserved_combination = c[5] && (c[2:0] > 3'h2);
    if (!c[5]) begin
      r.positive_source = (c[2:0] == 3'h6) ? acv_pkg::SRC_TEMPERATURE : {1'b0, c[2:0] - 3'(c[2:0] == 3'h7)};
      r.negative_source = (c[2:0] == 3'h6) ? acv_pkg::SRC_REFERENCE : acv_pkg::SRC_HALF_SUPPLY;
    end else begin
      r.positive_source = r.reserved_combination ? acv_pkg::SRC_NONE : {c[2:0], 1'b0};
      r.negative_source = r.reserved_combination ? acv_pkg::SRC_NONE : {c[2:0], 1'b1};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // One conversion: wrong triggers first, then the selected one, a settings change while busy, results.
  task automatic conv(input logic [7:0] c, input logic j, input logic [9:0] v, input logic [7:0] d);
    logic [3:0] sel;
    int n;
    sel = 4'h1 << c[4:3];
    just <= j;
    val <= v;
    dly <= d;
    wr_reg(acv_pkg::INPUT_CONTROL_ADDR, c);
    @(posedge clk);
    trig <= ~sel;
    @(posedge clk);
    trig <= sel;
    #1;
    cmp("start on other trigger", 16'h0000, 16'(start));
    @(posedge clk);
    #1;
    cmp("start", 16'h0001, 16'(start));
    cmp("busy", 16'h0001, 16'(busy));
    @(posedge clk);
    trig <= 4'h0;
    #1;
    cmp("start while busy", 16'h0000, 16'(start));
    cmp("route", 16'(exp_route(c)), 16'(route));
    wr_reg(acv_pkg::INPUT_CONTROL_ADDR, ~c);
    #1;
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp("busy after done", 16'h0000, 16'(busy));
    cmp("route kept", 16'(exp_route(c)), 16'(route));
    rd_chk(acv_pkg::RESULT_LOW_ADDR, j ? {v[1:0], 6'h00} : v[7:0]);
    rd_chk(acv_pkg::RESULT_HIGH_ADDR, j ? v[9:2] : {{6{v[9]}}, v[9:8]});
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    just = 1'b0;
    trig = 4'h0;
    rd_addr = 8'h00;
    dly = 8'h06;
    val = 10'h000;
    wr = '0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd_chk(acv_pkg::INPUT_CONTROL_ADDR, 8'h00);
    rd_chk(acv_pkg::RESULT_LOW_ADDR, 8'h00);
    rd_chk(8'h5a, 8'h00);
    wr_reg(acv_pkg::INPUT_CONTROL_ADDR, 8'h5a);
    rd_chk(acv_pkg::INPUT_CONTROL_ADDR, 8'h5a);
    wr_reg(acv_pkg::RESULT_LOW_ADDR, 8'h3c);
    rd_chk(acv_pkg::RESULT_LOW_ADDR, 8'h3c);
    for (int i = 0; i < 32; i++) begin
      // Differential settings only use the three defined pairs.
      conv({i[0], i[4], i[3], i[1:0], i[3] ? 3'(i[2:0] % 3) : i[2:0]}, i[1], {i[4:0], ~i[4:0]}, i[2] ? 8'h0c : 8'h06);
    end
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("watchdog expired before the tests ended");
    finish_test();
  end
endmodule
